// >>> hw/fad_decoder.sv
// command/result phase decoder for sense interrupt, sense drive, specify and invalid opcodes
`timescale 1ns/1ps
module fad_decoder
  import fad_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_seek_done,
  input  wire logic       i_seek_abnormal,
  input  wire logic [1:0] i_seek_drive,
  input  wire logic [1:0] i_seek_head,
  input  wire logic       i_poll_event,
  input  wire logic [7:0] i_pcn_0,
  input  wire logic [7:0] i_pcn_1,
  input  wire logic [7:0] i_pcn_2,
  input  wire logic [7:0] i_pcn_3,
  input  wire logic [7:0] i_drive_status,
  output logic      [7:0] o_rdata,
  output logic      [7:0] o_main_status,
  output logic            o_irq,
  output logic      [1:0] o_drive_sel,
  output logic            o_head_sel,
  output logic      [3:0] o_step_rate_time,
  output logic      [3:0] o_head_unload_time,
  output logic      [6:0] o_head_load_time,
  output logic            o_non_dma_flag
);
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_DRV   = 5'b00010,
    S_SPEC1 = 5'b00100,
    S_SPEC2 = 5'b01000,
    S_RES   = 5'b10000
  } fad_state_type;

  fad_state_type state;
  fad_state_type next_state;
  logic [1:0] kind;
  logic [1:0] next_kind;
  logic       res_idx;
  logic       next_res_idx;
  logic       irq_pend;
  logic       next_irq_pend;
  logic [7:0] int_st0;
  logic [7:0] next_int_st0;
  logic [1:0] int_drv;
  logic [1:0] next_int_drv;
  logic [1:0] drive_sel;
  logic [1:0] next_drive_sel;
  logic       head_sel;
  logic       next_head_sel;
  logic [3:0] step_rate_time;
  logic [3:0] next_srt;
  logic [3:0] head_unload_time;
  logic [3:0] next_hut;
  logic [6:0] head_load_time;
  logic [6:0] next_hlt;
  logic       nd;
  logic       next_nd;
  logic [7:0] rdata;
  logic [7:0] res_byte;
  logic [7:0] pcn_sel;
  logic [7:0] st3;
  logic [7:0] st0_snap;

  // drive status register: host status bits plus the addressed unit
  assign st3 = {i_drive_status[7:3], head_sel, drive_sel};

  always_comb begin
    unique case (int_drv)
      2'h0: pcn_sel = i_pcn_0;
      2'h1: pcn_sel = i_pcn_1;
      2'h2: pcn_sel = i_pcn_2;
      default: pcn_sel = i_pcn_3;
    endcase
  end

  // with no cause pending, sense interrupt reports polling
  assign st0_snap = irq_pend ? int_st0 : {IC_POLLING, 1'b0, 5'h00};

  fad_result_mux u_mux (
    .i_kind  (kind),
    .i_index (res_idx),
    .i_st0   (st0_snap),
    .i_pcn   (pcn_sel),
    .i_st3   (st3),
    .o_byte  (res_byte)
  );

  always_comb begin
    next_state    = state;
    next_kind     = kind;
    next_res_idx  = res_idx;
    next_irq_pend = irq_pend;
    next_int_st0  = int_st0;
    next_int_drv  = int_drv;
    next_drive_sel = drive_sel;
    next_head_sel = head_sel;
    next_srt      = step_rate_time;
    next_hut      = head_unload_time;
    next_hlt      = head_load_time;
    next_nd       = nd;
    unique case (state)
      S_IDLE: begin
        if (i_wr) begin
          next_res_idx = 1'b0;
          if (i_wdata == OP_SENSE_INT) begin
            next_kind  = 2'h0;
            next_state = S_RES;
          end else if (i_wdata == OP_SENSE_DRIVE) begin
            next_state = S_DRV;
          end else if (i_wdata == OP_SPECIFY) begin
            next_state = S_SPEC1;
          end else begin
            // no-op: no interrupt raised, single fixed result byte
            next_kind  = 2'h2;
            next_state = S_RES;
          end
        end
      end
      S_DRV: begin
        if (i_wr) begin
          next_head_sel  = i_wdata[2];
          next_drive_sel = i_wdata[1:0];
          next_kind      = 2'h1;
          next_state     = S_RES;
        end
      end
      S_SPEC1: begin
        if (i_wr) begin
          next_srt   = i_wdata[7:SRT_LSB];
          next_hut   = i_wdata[SRT_LSB-1:0];
          next_state = S_SPEC2;
        end
      end
      S_SPEC2: begin
        if (i_wr) begin
          next_hlt   = i_wdata[7:HLT_LSB];
          next_nd    = i_wdata[ND_POS];
          next_state = S_IDLE;
        end
      end
      S_RES: begin
        if (i_rd) begin
          if (kind == 2'h0 && !res_idx) begin
            next_res_idx = 1'b1;
            next_irq_pend = 1'b0;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
    // a seek ending in the clearing cycle is kept: set wins
    if (i_seek_done) begin
      next_irq_pend = 1'b1;
      next_int_drv  = i_seek_drive;
      next_int_st0  = {(i_seek_abnormal ? IC_ABNORMAL : IC_NORMAL), 1'b1, 2'h0,
                       i_seek_head[0], i_seek_drive};
    end else if (i_poll_event && !irq_pend) begin
      next_irq_pend = 1'b1;
      next_int_st0  = {IC_POLLING, 1'b0, 5'h00};
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (state == S_RES) begin
      rdata = res_byte;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state     <= S_IDLE;
      kind      <= 2'h0;
      res_idx   <= 1'b0;
      irq_pend  <= 1'b0;
      int_st0   <= 8'h00;
      int_drv   <= 2'h0;
      drive_sel <= 2'h0;
      head_sel  <= 1'b0;
      step_rate_time       <= SRT_RESET;
      head_unload_time       <= HUT_RESET;
      head_load_time       <= HLT_RESET;
      nd        <= ND_RESET;
      o_rdata   <= 8'h00;
    end else begin
      state     <= next_state;
      kind      <= next_kind;
      res_idx   <= next_res_idx;
      irq_pend  <= next_irq_pend;
      int_st0   <= next_int_st0;
      int_drv   <= next_int_drv;
      drive_sel <= next_drive_sel;
      head_sel  <= next_head_sel;
      step_rate_time       <= next_srt;
      head_unload_time       <= next_hut;
      head_load_time       <= next_hlt;
      nd        <= next_nd;
      o_rdata   <= rdata;
    end
  end

  // ready always; direction high in result phase so both bits show a waiting byte
  always_comb begin
    o_main_status = 8'h00;
    o_main_status[MSR_RQM_POS]  = 1'b1;
    o_main_status[MSR_DIO_POS]  = (state == S_RES);
    o_main_status[MSR_BUSY_POS] = (state != S_IDLE);
  end

  assign o_irq              = irq_pend;
  assign o_drive_sel        = drive_sel;
  assign o_head_sel         = head_sel;
  assign o_step_rate_time   = step_rate_time;
  assign o_head_unload_time = head_unload_time;
  assign o_head_load_time   = head_load_time;
  assign o_non_dma_flag     = nd;
endmodule

// >>> shared/fad_pkg.sv
// package: opcodes, field positions, status codes and reset values for the aux command decoder
package fad_pkg;
  localparam logic [7:0] OP_SENSE_INT   = 8'h08;
  localparam logic [7:0] OP_SENSE_DRIVE = 8'h04;
  localparam logic [7:0] OP_SPECIFY     = 8'h03;
  localparam logic [7:0] INVALID_ST0    = 8'h80;
  // status register zero layout
  localparam int         SEEK_END_POS   = 5;
  localparam int         IC_LSB         = 6;
  localparam logic [1:0] IC_NORMAL      = 2'h0;
  localparam logic [1:0] IC_ABNORMAL    = 2'h1;
  localparam logic [1:0] IC_POLLING     = 2'h3;
  // main status register bits
  localparam int         MSR_DIO_POS    = 6;
  localparam int         MSR_RQM_POS    = 7;
  localparam int         MSR_BUSY_POS   = 4;
  // specify fields
  localparam int         SRT_LSB        = 4;
  localparam int         HLT_LSB        = 1;
  localparam int         ND_POS         = 0;
  localparam logic [3:0] SRT_RESET      = 4'h0;
  localparam logic [3:0] HUT_RESET      = 4'h0;
  localparam logic [6:0] HLT_RESET      = 7'h00;
  localparam logic       ND_RESET       = 1'b0;
endpackage

// >>> hw/fad_result_mux.sv
// result byte selector: picks the byte shown on the data port per command and index
`timescale 1ns/1ps
module fad_result_mux
  import fad_pkg::*;
(
  input  wire logic [1:0] i_kind,
  input  wire logic       i_index,
  input  wire logic [7:0] i_st0,
  input  wire logic [7:0] i_pcn,
  input  wire logic [7:0] i_st3,
  output logic      [7:0] o_byte
);
  // kind 0: sense int, 1: sense drive, 2: invalid
  always_comb begin
    unique case (i_kind)
      2'h0:    o_byte = i_index ? i_pcn : i_st0;
      2'h1:    o_byte = i_st3;
      default: o_byte = INVALID_ST0;
    endcase
  end
endmodule

// >>> testbench/fad_decoder_props.sv
// checker: port-level properties of the aux command decoder
`timescale 1ns/1ps
module fad_decoder_props
  import fad_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic       i_seek_done,
  input wire logic       i_poll_event,
  input wire logic [7:0] i_drive_status,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_main_status,
  input wire logic       o_irq,
  input wire logic [3:0] o_step_rate_time,
  input wire logic [3:0] o_head_unload_time,
  input wire logic [6:0] o_head_load_time,
  input wire logic       o_non_dma_flag
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  logic idle_wr;
  logic bad_op;
  assign idle_wr = i_wr && !o_main_status[4];
  assign bad_op  = idle_wr && !(i_wdata inside {OP_SENSE_INT, OP_SENSE_DRIVE, OP_SPECIFY});
  // high from the sense opcode until its first result read, however slow the host is
  logic sense_first;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sense_first <= 1'b0;
    end else if (idle_wr && i_wdata == OP_SENSE_INT) begin
      sense_first <= 1'b1;
    end else if (i_rd) begin
      sense_first <= 1'b0;
    end
  end
  sequence spec_seq;
    idle_wr && i_wdata == OP_SPECIFY ##1 i_wr ##1 i_wr;
  endsequence
  a_sense_result: assert property (idle_wr && i_wdata == OP_SENSE_INT |=> o_main_status[6])
    else $error("no result phase after sense");
  a_irq_clear: assert property (sense_first && i_rd && !i_seek_done && !i_poll_event
    |=> !o_irq) else $error("irq not cleared");
  a_drive_result: assert property (idle_wr && i_wdata == OP_SENSE_DRIVE ##1 i_wr
    |=> o_main_status[6] ##1 o_rdata == {$past(i_drive_status[7:3]), $past(i_wdata[2:0], 2)})
    else $error("bad drive status byte");
  a_spec_timing: assert property (spec_seq
    |=> {o_step_rate_time, o_head_unload_time} == $past(i_wdata, 2)) else $error("bad step/unload");
  a_spec_load: assert property (spec_seq
    |=> {o_head_load_time, o_non_dma_flag} == $past(i_wdata)) else $error("bad load/nondma");
  a_spec_idle: assert property (spec_seq |=> o_main_status[6:4] == 3'h0)
    else $error("specify left device busy");
  a_invalid_quiet: assert property (bad_op && !o_irq
    ##1 (!i_seek_done && !i_poll_event)[*2] |-> !o_irq) else $error("invalid raised irq");
  a_invalid_result: assert property (bad_op |=> o_main_status[7:6] == 2'h3
    ##1 o_rdata == INVALID_ST0) else $error("bad invalid result");
  c_invalid: cover property (bad_op);
  c_specify: cover property (spec_seq);
  c_irq_clear: cover property ($fell(o_irq));
endmodule

// >>> testbench/fad_host_model.sv
// host model: writes command bytes and reads result bytes over the strobe ports
`timescale 1ns/1ps
module fad_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata
);
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end
  // strobe stays high across back-to-back bytes, dropped by rel
  task automatic wr(input logic [7:0] b);
    @(negedge i_clk);
    o_wr    = 1'b1;
    o_wdata = b;
  endtask
  // released data flips so a stale byte never looks valid
  task automatic rel();
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_wdata = ~o_wdata;
  endtask
  // sample a cycle after the state change since the result byte lags by one
  task automatic rd(output logic [7:0] b);
    @(negedge i_clk);
    b    = i_rdata;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
  endtask
endmodule

// >>> testbench/test_fad_decoder.sv
// testbench: host command sequences against the aux command decoder
`timescale 1ns/1ps
module test_fad_decoder;
  import fad_pkg::*;
  logic       i_clk           = 1'b0;
  logic       i_srst          = 1'b1;
  logic       i_seek_done     = 1'b0;
  logic       i_seek_abnormal = 1'b0;
  logic [1:0] i_seek_drive    = 2'h0;
  logic [1:0] i_seek_head     = 2'h0;
  logic       i_poll_event    = 1'b0;
  logic [7:0] i_drive_status  = 8'ha8;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] i_wdata;
  logic [7:0] o_rdata;
  logic [7:0] o_main_status;
  logic       o_irq;
  logic [1:0] o_drive_sel;
  logic       o_head_sel;
  logic [3:0] o_step_rate_time;
  logic [3:0] o_head_unload_time;
  logic [6:0] o_head_load_time;
  logic       o_non_dma_flag;
  logic [7:0] b;
  logic [7:0] ops [2] = '{8'h00, 8'hff};
  logic [15:0] sp [2] = '{16'ha72b, 16'h5cfe};
  int         n_errors        = 0;
  int         samples_checked = 0;
  always #5 i_clk = ~i_clk;
  fad_decoder dut (.*, .i_pcn_0(8'h11), .i_pcn_1(8'h4e), .i_pcn_2(8'h9c), .i_pcn_3(8'hf0));
  fad_host_model host (.i_clk, .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ev(input logic pl, input logic abn, input logic [1:0] drv, input logic [1:0] hd);
    @(negedge i_clk);
    i_poll_event    = pl;
    i_seek_done     = !pl;
    i_seek_abnormal = abn;
    i_seek_drive    = drv;
    i_seek_head     = hd;
    @(negedge i_clk);
    i_poll_event    = 1'b0;
    i_seek_done     = 1'b0;
  endtask
  // m masks head and drive bits of st0 and the cylinder byte where they are not defined
  task automatic sense(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] m);
    host.wr(OP_SENSE_INT);
    host.rel();
    chk("result phase", o_main_status & 8'h40, 8'h40);
    host.rd(b);
    chk("st0", b & {5'h1f, m[2:0]}, e0 & {5'h1f, m[2:0]});
    host.rd(b);
    chk("pcn", b & m, e1 & m);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge i_clk);
    i_srst = 1'b0;
    chk("main idle", o_main_status, 8'h80);
    ev(1'b0, 1'b0, 2'h2, 2'h1);
    chk("irq set", {7'h0, o_irq}, 8'h01);
    sense(8'h26, 8'h9c, 8'hff);
    chk("irq cleared", {7'h0, o_irq}, 8'h00);
    ev(1'b0, 1'b1, 2'h1, 2'h0);
    sense(8'h61, 8'h4e, 8'hff);
    ev(1'b1, 1'b0, 2'h0, 2'h0);
    sense(8'hc0, 8'h4e, 8'hff);
    // nothing pending: still reads as polling, cylinder of last seek
    sense(8'hc0, 8'h4e, 8'hff);
    $display("sense interrupt test done");
    host.wr(OP_SENSE_DRIVE);
    host.wr(8'h06);
    host.rel();
    host.rd(b);
    chk("drive status", b, 8'hae);
    chk("drive select", {5'h0, o_head_sel, o_drive_sel}, 8'h06);
    $display("sense drive test done");
    for (int k = 0; k < 2; k++) begin
      host.wr(OP_SPECIFY);
      host.wr(sp[k][15:8]);
      host.wr(sp[k][7:0]);
      host.rel();
      chk("specify idle", o_main_status, 8'h80);
      chk("srt hut", {o_step_rate_time, o_head_unload_time}, sp[k][15:8]);
      chk("hlt nd", {o_head_load_time, o_non_dma_flag}, sp[k][7:0]);
    end
    $display("specify test done");
    for (int k = 0; k < 2; k++) begin
      host.wr(ops[k]);
      host.rel();
      chk("invalid status", o_main_status & 8'hc0, 8'hc0);
      chk("invalid irq", {7'h0, o_irq}, 8'h00);
      host.rd(b);
      chk("invalid st0", b, INVALID_ST0);
      chk("back to idle", o_main_status, 8'h80);
    end
    $display("invalid opcode test done");
    print_verdict();
  end
endmodule
bind fad_decoder fad_decoder_props u_props (.*);
